/* File: hw/timer_pkg.sv */
// Constants, register map and carrier types of the gated down-counter timer.
// Assumes a single 250 MHz clock and inputs already synchronous to it.
//
// Behaviour
// R1: Output polarity bit selects high or low active.
// R2: Input A select: rise to A, fall to B.
// R3: Input B select: rise to A, fall to B.
// R4: Invert bit swaps rising and falling edges.
// R5: Both inputs into one register: no store.
// R6: Hardware capture registers read/write, reset zero.
// R7: Software write beats simultaneous capture.
// R8: Soft pulse rising edge captures count, resets zero.
// R9: Soft pulse comes from trigger register writes.
// R10: Counter loads in exactly four documented cases.
// R11: Count or load only with run and clock.
// R12: Reinit loads counter regardless of run enable.
// R13: Edge actions take effect within three clocks.
// R14: Gate mode counts prescaled while gate active.
// R15: Count mode steps on each active edge.
// R16: Trigger mode edge reloads unless count equals load.
// R17: Toggle mode edge reloads or decrements.
// R18: Trigger source select: software or hardware signal.
// R19: Drivers hold each level one clock minimum.
// R20: Gate edges spaced three clocks plus prescale.
// R21: Event edges spaced at least two clocks.
// R22: Output active exactly while counter is zero.
// R23: One-shot zero stops, otherwise reload at zero.
// R24: Eight-bit prescaler divides by start plus one.
// R25: Reinit self-clears, clears captures and edge detectors.
// R26: Edges found by comparing present and previous samples.
// R27: Counter and captures share one parameter width.

package timer_pkg;

    // ************************************************************
    // Bus and widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam int PRESC_W = 8;
    localparam int MODE_W = 14;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRESC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAP_A = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAP_B = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CAP_SOFT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SOFT_EVENT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_SOFT_GATE = 8'h20;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int MODE_REINIT_BIT = 0;
    localparam int SOFT_GATE_BIT = 0;
    localparam logic [MODE_W-1:0] MODE_RST = 14'h0000;
    localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h00000000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Mode register, bit 13 down to bit 0
    typedef struct packed {
        logic event_b_invert;
        logic event_a_invert;
        logic [1:0] event_b_edge_select;
        logic [1:0] event_a_edge_select;
        logic out_low_active;
        logic gate_effect;
        logic gate_low_active;
        logic hw_trigger_select;
        logic load_write_at_zero;
        logic one_shot;
        logic count_source;
        logic reinit;
    } mode_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_t;

endpackage : timer_pkg

/* File: hw/edge_detect.sv */
// One edge detector sampling a clock-synchronous level.
// Assumes the input is already synchronous to clk.
`timescale 1ns/100ps

module edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    // Level in, edges out
    input wire logic sig,
    output timer_pkg::edge_t edges
);

    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t state_q;
    edge_state_t state_d;

    // Previous sample compared with present one; see R26
    always_comb begin
        state_d.prev = sig;
        edges.rise = sig & ~state_q.prev & ~clear;
        edges.fall = ~sig & state_q.prev & ~clear;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : edge_detect

/* File: hw/gated_down_counter_with_capture.sv */
// One down-counting timer channel with prescaler, four count modes and three capture registers.
// Assumes gate and event inputs synchronous to clk; registers reached over a plain strobe port.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module gated_down_counter_with_capture #(
    parameter int WIDTH = timer_pkg::CNT_W // see R27
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [timer_pkg::DATA_W-1:0] rdata,
    // Timer control and inputs
    input wire logic run_en,
    input wire logic gate_ext,
    input wire logic event_in_a,
    input wire logic event_in_b,
    // Timer output
    output logic zero_count_output
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        timer_pkg::mode_t mode;
        logic [WIDTH-1:0] load;
        logic [timer_pkg::PRESC_W-1:0] divider_start_value;
        logic [timer_pkg::PRESC_W-1:0] presc;
        logic [WIDTH-1:0] count;
        logic [WIDTH-1:0] cap_a;
        logic [WIDTH-1:0] cap_b;
        logic [WIDTH-1:0] cap_soft;
        logic soft_gate;
        logic soft_event_pulse;
        logic load_pend;
        logic trig_pend;
        logic [timer_pkg::DATA_W-1:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    timer_pkg::bus_req_t req;
    timer_pkg::mode_t wmode;
    timer_pkg::edge_t gate_edges;
    timer_pkg::edge_t ev_a_edges;
    timer_pkg::edge_t ev_b_edges;
    timer_pkg::edge_t soft_edges;

    logic reinit;
    logic gate_level;
    logic gate_active;
    logic gate_edge;
    logic presc_run;
    logic tick;
    logic count_is_load;
    logic count_is_zero;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic cap_a_ev;
    logic cap_b_ev;
    logic clash_a;
    logic clash_b;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [timer_pkg::DATA_W-1:0] widen(input logic [WIDTH-1:0] v);
        logic [timer_pkg::DATA_W-1:0] r;
        r = '0;
        r[WIDTH-1:0] = v;
        return r;
    endfunction : widen

    always_comb begin
        req.addr = addr;
        req.wdata = wdata;
        req.wr = wr;
        req.rd = rd;
        wmode = timer_pkg::mode_t'(wdata[timer_pkg::MODE_W-1:0]);
    end

    assign reinit = req.wr && (req.addr == timer_pkg::OFS_MODE) && req.wdata[timer_pkg::MODE_REINIT_BIT];

    // ************************************************************
    // Edge detectors
    // ************************************************************
    assign gate_level = s_q.mode.hw_trigger_select ? gate_ext : s_q.soft_gate; // see R18

    edge_detect u_gate_edge (
        .clk(clk),
        .rst_n(rst_n),
        .clear(reinit),
        .sig(gate_level),
        .edges(gate_edges)
    );

    edge_detect u_event_a_edge (
        .clk(clk),
        .rst_n(rst_n),
        .clear(reinit),
        .sig(event_in_a),
        .edges(ev_a_edges)
    );

    edge_detect u_event_b_edge (
        .clk(clk),
        .rst_n(rst_n),
        .clear(reinit),
        .sig(event_in_b),
        .edges(ev_b_edges)
    );

    edge_detect u_soft_edge (
        .clk(clk),
        .rst_n(rst_n),
        .clear(reinit),
        .sig(s_q.soft_event_pulse),
        .edges(soft_edges)
    );

    // ************************************************************
    // Gate, prescaler and count/load clock
    // ************************************************************
    always_comb begin
        gate_active = gate_level ^ s_q.mode.gate_low_active; // see R14
        gate_edge = s_q.mode.gate_low_active ? gate_edges.fall : gate_edges.rise; // see R15
        // Prescaler stalls without run enable or with a passive gate in gate mode
        presc_run = run_en && !s_q.mode.count_source && (s_q.mode.gate_effect || gate_active); // see R14
        if (s_q.mode.count_source) begin
            tick = run_en && gate_edge; // see R11
        end else begin
            tick = presc_run && (s_q.presc == '0); // see R24
        end
        count_is_load = (s_q.count == s_q.load);
        count_is_zero = (s_q.count == '0);
    end

    // ************************************************************
    // Capture selection
    // ************************************************************
    always_comb begin
        a_rise = s_q.mode.event_a_invert ? ev_a_edges.fall : ev_a_edges.rise; // see R4
        a_fall = s_q.mode.event_a_invert ? ev_a_edges.rise : ev_a_edges.fall; // see R4
        b_rise = s_q.mode.event_b_invert ? ev_b_edges.fall : ev_b_edges.rise; // see R4
        b_fall = s_q.mode.event_b_invert ? ev_b_edges.rise : ev_b_edges.fall; // see R4
        // Both inputs aimed at one register is forbidden
        clash_a = s_q.mode.event_a_edge_select[0] && s_q.mode.event_b_edge_select[0]; // see R5
        clash_b = s_q.mode.event_a_edge_select[1] && s_q.mode.event_b_edge_select[1]; // see R5
        cap_a_ev = !clash_a && ((s_q.mode.event_a_edge_select[0] && a_rise) ||
                                (s_q.mode.event_b_edge_select[0] && b_rise)); // see R2 see R3
        cap_b_ev = !clash_b && ((s_q.mode.event_a_edge_select[1] && a_fall) ||
                                (s_q.mode.event_b_edge_select[1] && b_fall)); // see R2 see R3
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.soft_event_pulse = 1'b0;
        s_d.rdata = timer_pkg::WORD_RST;

        // Prescaler
        if (presc_run) begin
            if (s_q.presc == '0) begin
                s_d.presc = s_q.divider_start_value; // see R24
            end else begin
                s_d.presc = s_q.presc - 1'b1; // see R24
            end
        end

        // Counter on the count/load clock
        if (tick) begin
            if (s_q.mode.count_source && s_q.mode.gate_effect) begin
                if (!count_is_load) begin
                    s_d.count = s_q.load; // see R17
                end else if (!count_is_zero) begin
                    s_d.count = s_q.count - 1'b1; // see R17
                end
                s_d.load_pend = 1'b0;
            end else if (s_q.trig_pend && !count_is_load) begin
                s_d.count = s_q.load; // see R16 see R10
                s_d.trig_pend = 1'b0;
                s_d.load_pend = 1'b0;
            end else if (s_q.load_pend) begin
                s_d.count = s_q.load; // see R10
                s_d.load_pend = 1'b0;
                s_d.trig_pend = 1'b0;
            end else if (count_is_zero) begin
                if (!s_q.mode.one_shot) begin
                    s_d.count = s_q.load; // see R23 see R10
                end
                s_d.trig_pend = 1'b0;
            end else begin
                s_d.count = s_q.count - 1'b1; // see R11
                s_d.trig_pend = 1'b0;
            end
        end

        // Trigger request set after the tick, so a same-cycle tick cannot drop it
        if (!s_q.mode.count_source && s_q.mode.gate_effect && gate_edge) begin
            s_d.trig_pend = 1'b1; // see R16
        end

        // Captures, overridden below by software writes
        if (cap_a_ev) begin
            s_d.cap_a = s_q.count; // see R2
        end
        if (cap_b_ev) begin
            s_d.cap_b = s_q.count; // see R3
        end
        if (soft_edges.rise) begin
            s_d.cap_soft = s_q.count; // see R8 see R13
        end

        // Register writes
        if (req.wr) begin
            case (req.addr)
                timer_pkg::OFS_MODE: begin
                    s_d.mode = wmode;
                    s_d.mode.reinit = 1'b0; // see R25
                end
                timer_pkg::OFS_LOAD: begin
                    s_d.load = req.wdata[WIDTH-1:0];
                    if (run_en && !s_q.mode.load_write_at_zero) begin
                        s_d.load_pend = 1'b1; // see R10
                    end
                end
                timer_pkg::OFS_PRESC: begin
                    s_d.divider_start_value = req.wdata[timer_pkg::PRESC_W-1:0];
                end
                timer_pkg::OFS_CAP_A: begin
                    s_d.cap_a = req.wdata[WIDTH-1:0]; // see R6 see R7
                end
                timer_pkg::OFS_CAP_B: begin
                    s_d.cap_b = req.wdata[WIDTH-1:0]; // see R6 see R7
                end
                timer_pkg::OFS_CAP_SOFT: begin
                    s_d.cap_soft = req.wdata[WIDTH-1:0]; // see R8
                end
                timer_pkg::OFS_SOFT_EVENT: begin
                    s_d.soft_event_pulse = 1'b1; // see R9
                end
                timer_pkg::OFS_SOFT_GATE: begin
                    s_d.soft_gate = req.wdata[timer_pkg::SOFT_GATE_BIT];
                end
                default: begin
                end
            endcase
        end

        // Reinit: restart counter and prescaler, clear captures
        if (reinit) begin
            s_d.count = s_q.load; // see R12 see R10
            s_d.presc = s_q.divider_start_value; // see R25
            s_d.cap_a = '0; // see R25
            s_d.cap_b = '0; // see R25
            s_d.cap_soft = '0; // see R25
            s_d.load_pend = 1'b0;
            s_d.trig_pend = 1'b0;
        end

        // Register reads, data in the following cycle
        if (req.rd) begin
            case (req.addr)
                timer_pkg::OFS_MODE: begin
                    s_d.rdata = {{(timer_pkg::DATA_W-timer_pkg::MODE_W){1'b0}}, s_q.mode}; // see R25
                end
                timer_pkg::OFS_LOAD: begin
                    s_d.rdata = widen(s_q.load);
                end
                timer_pkg::OFS_PRESC: begin
                    s_d.rdata = {{(timer_pkg::DATA_W-timer_pkg::PRESC_W){1'b0}}, s_q.divider_start_value};
                end
                timer_pkg::OFS_COUNT: begin
                    s_d.rdata = widen(s_q.count);
                end
                timer_pkg::OFS_CAP_A: begin
                    s_d.rdata = widen(s_q.cap_a); // see R6
                end
                timer_pkg::OFS_CAP_B: begin
                    s_d.rdata = widen(s_q.cap_b); // see R6
                end
                timer_pkg::OFS_CAP_SOFT: begin
                    s_d.rdata = widen(s_q.cap_soft); // see R8
                end
                timer_pkg::OFS_SOFT_GATE: begin
                    s_d.rdata = {{(timer_pkg::DATA_W-1){1'b0}}, s_q.soft_gate};
                end
                default: begin
                    s_d.rdata = timer_pkg::WORD_RST;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q.mode <= timer_pkg::mode_t'(timer_pkg::MODE_RST);
            s_q.load <= '0;
            s_q.divider_start_value <= timer_pkg::PRESC_RST;
            s_q.presc <= timer_pkg::PRESC_RST;
            s_q.count <= '0;
            s_q.cap_a <= '0; // see R6
            s_q.cap_b <= '0; // see R6
            s_q.cap_soft <= '0; // see R8
            s_q.soft_gate <= 1'b0;
            s_q.soft_event_pulse <= 1'b0;
            s_q.load_pend <= 1'b0;
            s_q.trig_pend <= 1'b0;
            s_q.rdata <= timer_pkg::WORD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata = s_q.rdata;
    assign zero_count_output = (s_q.count == '0) ^ s_q.mode.out_low_active; // see R22 see R1

endmodule : gated_down_counter_with_capture

/* File: testbench/ext_sources.sv */
// Model of the trigger and event sources outside the timer.
// Assumes one-clock commands from the bench, given only while idle.
`timescale 1ns/100ps

module ext_sources (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench command
    input wire logic go,
    input wire logic [1:0] sel,
    output logic busy,
    // Lines into the timer
    output logic gate_ext,
    output logic event_in_a,
    output logic event_in_b
);
    logic [2:0] lv_q;
    logic [2:0] hold_q;

    // Each level held five clocks before the next change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lv_q <= 3'h0;
            hold_q <= 3'h0;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else if (go) begin
            lv_q[sel] <= ~lv_q[sel];
            hold_q <= 3'h4;
        end
    end

    assign busy = (hold_q != 3'h0);
    assign gate_ext = lv_q[0];
    assign event_in_a = lv_q[1];
    assign event_in_b = lv_q[2];
endmodule : ext_sources

/* File: testbench/timer_monitor.sv */
// Checker on the top ports of the timer channel.
// Assumes it is bound to the top module with all ports by name.
`timescale 1ns/100ps

module timer_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [timer_pkg::DATA_W-1:0] rdata,
    // Timer pins
    input wire logic run_en,
    input wire logic gate_ext,
    input wire logic event_in_a,
    input wire logic event_in_b,
    input wire logic zero_count_output
);
    logic [timer_pkg::DATA_W-1:0] load_q;
    logic pol_q;
    logic a_q;
    logic b_q;
    logic quiet;
    logic mode_wr;

    // Shadow of load value and output polarity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_q <= '0;
            pol_q <= 1'b0;
        end else if (wr && addr == timer_pkg::OFS_LOAD) begin
            load_q <= wdata;
        end else if (mode_wr) begin
            pol_q <= wdata[7];
        end
    end

    always_ff @(posedge clk) begin
        a_q <= event_in_a;
        b_q <= event_in_b;
    end

    assign quiet = (event_in_a == a_q) && (event_in_b == b_q);
    assign mode_wr = wr && addr == timer_pkg::OFS_MODE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_MODE_READ: assert property (rd && addr == timer_pkg::OFS_MODE |=> rdata[0] == 1'b0)
        else $error("reinit bit read back as one");
    AST_REINIT_LOAD: assert property (mode_wr && wdata[0] |=> zero_count_output == ((load_q == '0) ^ pol_q))
        else $error("output wrong after reinit");
    AST_OUT_TRACKS_COUNT: assert property (rd && addr == timer_pkg::OFS_COUNT && !run_en
        |=> (rdata == '0) == (zero_count_output != pol_q)) else $error("output disagrees with count");
    AST_HOLD_WITHOUT_RUN: assert property (!run_en && !mode_wr |=> $stable(zero_count_output))
        else $error("count moved while stopped");
    AST_CAP_A_RW: assert property ((wr && addr == timer_pkg::OFS_CAP_A && quiet) ##1 quiet
        ##1 (rd && addr == timer_pkg::OFS_CAP_A && quiet) |=> rdata == $past(wdata, 3)) else $error("cap a lost");
    AST_CAP_B_RW: assert property ((wr && addr == timer_pkg::OFS_CAP_B && quiet) ##1 quiet
        ##1 (rd && addr == timer_pkg::OFS_CAP_B && quiet) |=> rdata == $past(wdata, 3)) else $error("cap b lost");
    AST_CAP_SOFT_RW: assert property ((wr && addr == timer_pkg::OFS_CAP_SOFT) ##2
        (rd && addr == timer_pkg::OFS_CAP_SOFT) |=> rdata == $past(wdata, 3)) else $error("cap soft lost");
    AST_REINIT_CLEARS: assert property ((mode_wr && wdata[0]) ##1 quiet
        ##1 (rd && addr == timer_pkg::OFS_CAP_A) |=> rdata == '0) else $error("capture not cleared");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == '0)
        else $error("read data outside read slot");
endmodule : timer_monitor

/* File: testbench/tb_top.sv */
// Self-checking bench for the timer channel and its source model.
// Assumes package, design, source model and checker compile first.
`timescale 1ns/100ps

module tb_top;
    // ********************
    // Signals
    // ********************
    localparam logic [7:0] A_MODE = timer_pkg::OFS_MODE;
    localparam logic [7:0] A_LOAD = timer_pkg::OFS_LOAD;
    localparam logic [7:0] A_CNT = timer_pkg::OFS_COUNT;
    localparam logic [7:0] A_CA = timer_pkg::OFS_CAP_A;
    localparam logic [7:0] A_CB = timer_pkg::OFS_CAP_B;
    localparam logic [7:0] A_CS = timer_pkg::OFS_CAP_SOFT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic run_en = 1'b0;
    logic go = 1'b0;
    logic [1:0] sel = 2'h0;
    logic busy;
    logic gate_ext;
    logic event_in_a;
    logic event_in_b;
    logic zero_count_output;
    int bad_count = 0;
    int n_compared = 0;

    always #2 clk = ~clk;

    gated_down_counter_with_capture i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .run_en(run_en), .gate_ext(gate_ext), .event_in_a(event_in_a),
        .event_in_b(event_in_b), .zero_count_output(zero_count_output));
    ext_sources i_src (.clk(clk), .rst_n(rst_n), .go(go), .sel(sel), .busy(busy), .gate_ext(gate_ext),
        .event_in_a(event_in_a), .event_in_b(event_in_b));

    // ********************
    // Tasks
    // ********************
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : chk_rd

    // One level change on a source line, then the action delay
    task automatic toggle(input logic [1:0] s);
        int i;
        @(posedge clk);
        go <= 1'b1;
        sel <= s;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (i = 0; i < 20 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) begin
            bad_count++;
            end_of_test();
        end
        repeat (3) @(posedge clk);
    endtask : toggle

    task automatic t_regs();
        logic [7:0] caps[3] = '{A_CA, A_CB, A_CS};
        int i;
        chk("out", 32'h1, {31'h0, zero_count_output});
        chk_rd("mode", A_MODE, 32'h0);
        chk_rd("count", A_CNT, 32'h0);
        for (i = 0; i < 3; i++) begin
            chk_rd("cap", caps[i], 32'h0);
            wr_reg(caps[i], 32'h5A5AC3C0 + 32'(i));
            chk_rd("cap", caps[i], 32'h5A5AC3C0 + 32'(i));
        end
        wr_reg(A_LOAD, 32'h5);
        wr_reg(A_MODE, 32'h1);
        chk_rd("cap_a", A_CA, 32'h0);
        chk_rd("count", A_CNT, 32'h5);
        chk("out", 32'h0, {31'h0, zero_count_output});
        wr_reg(A_MODE, 32'h80);
        chk("out", 32'h1, {31'h0, zero_count_output});
        chk_rd("unmapped", 8'h40, 32'h0);
        $display("registers done");
    endtask : t_regs

    task automatic t_capture();
        int n;
        int s;
        int v;
        logic [31:0] l;
        for (n = 0; n < 2; n++) begin
            for (s = 1; s < 4; s++) begin
                for (v = 0; v < 2; v++) begin
                    l = 32'h40 + 32'(n * 8 + s * 2 + v);
                    wr_reg(A_LOAD, l);
                    wr_reg(A_MODE, 32'h1 | (32'(s) << (8 + 2 * n)) | (32'(v) << (12 + n)));
                    toggle(2'(n + 1));
                    chk_rd("cap_a", A_CA, (v == 0 && s[0]) ? l : 32'h0);
                    chk_rd("cap_b", A_CB, (v == 1 && s[1]) ? l : 32'h0);
                    toggle(2'(n + 1));
                    chk_rd("cap_a", A_CA, s[0] ? l : 32'h0);
                    chk_rd("cap_b", A_CB, s[1] ? l : 32'h0);
                end
            end
        end
        wr_reg(A_MODE, 32'h0501);
        toggle(2'h1);
        chk_rd("cap_a", A_CA, 32'h0);
        toggle(2'h1);
        $display("capture done");
    endtask : t_capture

    // Four active gate edges, count read after each
    task automatic t_mode(input logic [31:0] m, input logic [31:0] l, input logic [3:0][7:0] e);
        int i;
        wr_reg(A_LOAD, l);
        wr_reg(A_MODE, m);
        @(posedge clk);
        run_en <= 1'b1;
        for (i = 0; i < 4; i++) begin
            if (m[4]) begin
                toggle(2'h0);
                toggle(2'h0);
            end else begin
                wr_reg(timer_pkg::OFS_SOFT_GATE, 32'h1);
                repeat (3) @(posedge clk);
                wr_reg(timer_pkg::OFS_SOFT_GATE, 32'h0);
                repeat (3) @(posedge clk);
            end
            chk_rd("count", A_CNT, {24'h0, e[i]});
            if (i == 1 && m[2]) begin
                wr_reg(timer_pkg::OFS_SOFT_EVENT, 32'h0);
                repeat (2) @(posedge clk);
                chk_rd("cap_soft", A_CS, {24'h0, e[1]});
            end
        end
        chk("out", {31'h0, m[7] ^ (e[3] == 8'h00)}, {31'h0, zero_count_output});
        @(posedge clk);
        run_en <= 1'b0;
        $display("mode %h done", m);
    endtask : t_mode

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_capture();
        t_mode(32'h17, 32'h3, {8'h00, 8'h00, 8'h01, 8'h02});
        t_mode(32'h13, 32'h3, {8'h03, 8'h00, 8'h01, 8'h02});
        t_mode(32'hC3, 32'h2, {8'h02, 8'h01, 8'h02, 8'h01});
        t_mode(32'h41, 32'h40, {8'h39, 8'h39, 8'h39, 8'h39});
        wr_reg(timer_pkg::OFS_PRESC, 32'h1);
        t_mode(32'h01, 32'h40, {8'h36, 8'h39, 8'h3B, 8'h3E});
        end_of_test();
    end
endmodule : tb_top

bind gated_down_counter_with_capture timer_monitor i_mon (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_en(run_en), .gate_ext(gate_ext),
    .event_in_a(event_in_a), .event_in_b(event_in_b), .zero_count_output(zero_count_output));
